// ===== rtl/pmid_pkg.sv
// Package with the register map, field layout and page codes of the identification bank
package pmid_pkg;

  // Byte offsets inside each feature page
  localparam logic [11:0] PRI_IDR_OFFSET   = 12'h048;  // Priority partitioning identification
  localparam logic [11:0] NRW_IDR_OFFSET   = 12'h050;  // Partition narrowing identification
  localparam logic [11:0] MSMON_IDR_OFFSET = 12'h080;  // Monitoring feature identification

  // Address layout: page select above a 4 KiB frame
  localparam int ADDR_W      = 14;                     // Byte address width
  localparam int PAGE_LSB    = 12;                     // First bit of the page select
  localparam int INST_W      = 4;                      // Resource instance field width
  localparam int NUM_INST    = 16;                     // Instances addressable by the field
  localparam int NUM_PAGES   = 4;                      // Security pages

  // Page codes carried in address bits [13:12]
  localparam logic [1:0] PAGE_S  = 2'h0;               // Secure page
  localparam logic [1:0] PAGE_NS = 2'h1;               // Non-secure page
  localparam logic [1:0] PAGE_RT = 2'h2;               // Root page
  localparam logic [1:0] PAGE_RL = 2'h3;               // Realm page

  // Field positions
  localparam int CSU_BIT     = 16;                     // Cache usage monitor present
  localparam int NRW_MAX_LSB = 0;                      // Largest internal partition, low bit
  localparam int NRW_MAX_W   = 16;                     // Largest internal partition, width

  // Reset value of the read data register
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Bus state machine, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,                                  // Waiting for a request
    ST_LOOK = 3'b010,                                  // Instance table read in flight
    ST_DONE = 3'b100                                   // Answer on the outputs
  } pmid_state_e;

endpackage : pmid_pkg

// ===== rtl/pmid_inst_table.sv
// Small memory holding per-instance cache usage monitor presence, one bit per page
`timescale 1ns/1ps
module pmid_inst_table (
  input  wire logic                            clk,       // System clock
  input  wire logic                            nrst,      // Asynchronous reset, active low
  input  wire logic [pmid_pkg::NUM_INST*4-1:0] tableBits, // Static per-instance capability
  input  wire logic [pmid_pkg::INST_W-1:0]     rdInst,    // Instance to look up
  output logic      [3:0]                      rdData     // Registered lookup result
);

  // Registered read, one bit per security page
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 4'h0;
    end else begin
      rdData <= tableBits[rdInst*4 +: 4];
    end
  end

endmodule : pmid_inst_table

// ===== rtl/pmid_page_decode.sv
// Page and offset decode of a register request into a one-hot register hit
`timescale 1ns/1ps
module pmid_page_decode (
  input  wire logic [pmid_pkg::ADDR_W-1:0] addr,      // Byte address of the request
  input  wire logic                        realmOn,   // Realm feature present
  output logic      [1:0]                  page,      // Security page of the request
  output logic                             pageOk,    // Page exists in this build
  output logic                             hitPri,    // Priority identification hit
  output logic                             hitNrw,    // Narrowing identification hit
  output logic                             hitMon     // Monitoring identification hit
);

  logic [11:0] offs;                                  // Offset within the frame

  // Split address, check the page and the offset
  always_comb begin
    offs   = addr[pmid_pkg::PAGE_LSB-1:0];
    page   = addr[pmid_pkg::ADDR_W-1:pmid_pkg::PAGE_LSB];
    // Root and realm pages hit registers only with the realm feature
    pageOk = (page == pmid_pkg::PAGE_S) || (page == pmid_pkg::PAGE_NS) || realmOn;
    hitPri = (offs == pmid_pkg::PRI_IDR_OFFSET);
    hitNrw = (offs == pmid_pkg::NRW_IDR_OFFSET);
    hitMon = (offs == pmid_pkg::MSMON_IDR_OFFSET);
  end

endmodule : pmid_page_decode

// ===== rtl/pmid_id_regs.sv
// Read-only identification registers of the partition monitor, four security pages
//
// Notes on behaviour
// - Cache usage monitor bit shows presence
// - That bit follows the selected resource instance
// - Four security feature pages provided
// - Separate register instance behind each page
// - Page instances may hold equal or differing values
// - Instance fields track selection, others stay constant
// - Monitor select instance field is ignored
// - Monitoring register at 0x80, read-only
// - Root and realm pages need realm feature
// - Each page reports its own largest partition
// - Narrowing value independent of selected instance
// - Largest partition in low sixteen bits
// - Narrowing register at 0x50, read-only
// - Priority register only when flag set
// - Priority instance fields follow the selection
// - Monitoring register only when flag set
`timescale 1ns/1ps
module pmid_id_regs #(
  parameter logic                            REALM_ON  = 1'b1,         // Realm feature
  parameter logic                            MON_ON    = 1'b1,         // Monitoring present
  parameter logic                            NRW_ON    = 1'b1,         // Narrowing present
  parameter logic                            PRI_ON    = 1'b1,         // Priority partitioning
  parameter logic                            RIS_ON    = 1'b1,         // Instance select present
  parameter logic [pmid_pkg::NUM_INST*4-1:0] CSU_TABLE = 64'h0000_f0f0_ffff_00ff, // Plain default
  parameter logic [63:0]                     NRW_MAX   = 64'h003f_001f_00ff_007f, // Per page
  parameter logic [pmid_pkg::NUM_INST*32-1:0] PRI_TABLE = '0              // Per instance value
) (
  input  wire logic                        clk,        // System clock
  input  wire logic                        nrst,       // Asynchronous reset, active low
  input  wire logic                        req,        // Register request strobe
  input  wire logic                        wr,         // Write when high, read when low
  input  wire logic [pmid_pkg::ADDR_W-1:0] addr,       // Byte address, page in top bits
  input  wire logic [31:0]                 wdata,      // Write data, discarded
  input  wire logic [pmid_pkg::INST_W-1:0] partSelInst,// Partition select instance field
  input  wire logic [pmid_pkg::INST_W-1:0] monSelInst, // Monitor select instance field
  output logic                             ack,        // One-cycle answer pulse
  output logic [31:0]                      rdata,      // Read data, held until next answer
  output logic                             busy        // Request in progress
);

  pmid_pkg::pmid_state_e state_r;                     // Bus state
  logic [1:0]            page;                        // Decoded page
  logic                  pageOk;                      // Page exists
  logic                  hitPri;                      // Offset hits
  logic                  hitNrw;
  logic                  hitMon;
  logic [1:0]            page_r;                      // Captured page
  logic [2:0]            hit_r;                       // Captured hits {pri, nrw, mon}
  logic                  rd_r;                        // Captured read flag
  logic [pmid_pkg::INST_W-1:0] inst_r;                // Captured instance
  logic [3:0]            csuBits;                     // Table lookup per page
  logic [31:0]           rdata_nxt;                   // Answer being formed

  // Register map of one 4 KiB feature page
  //   Page 0 secure, page 1 non-secure
  //   Page 2 root, page 3 realm
  //   Root and realm need the realm feature
  //
  // Priority identification, offset 0x48
  //   One word per resource instance
  //   Words come from PRI_TABLE
  //   Reads zero unless PRI_ON
  //
  // Narrowing identification, offset 0x50
  //   Bits 15:0 largest internal partition
  //   Bits 31:16 reserved, read zero
  //   One value per page, not per instance
  //   Reads zero unless NRW_ON
  //
  // Monitoring identification, offset 0x80
  //   Bit 16 cache usage monitor present
  //   Looked up per page and instance
  //   Other bits reserved, read zero
  //   Reads zero unless MON_ON
  //
  // Instance selection
  //   With RIS_ON the partition select field picks the row
  //   Without it every lookup uses row zero
  //   Monitor select field never alters an answer
  //
  // Access
  //   Every location is read-only
  //   Writes are answered and change nothing
  //   Unmapped offsets read zero
  //   Page and instance taken at the request edge
  //
  // Timing of one request
  //   Edge 0 request taken, table row read
  //   Edge 1 answer and ack registered
  //   Edge 2 ack seen high, then dropped
  //   Edge 3 busy low, next request taken
  //   Requests while busy are dropped

  // Page and offset decode
  pmid_page_decode uDec (
    .addr    (addr),
    .realmOn (REALM_ON),
    .page    (page),
    .pageOk  (pageOk),
    .hitPri  (hitPri),
    .hitNrw  (hitNrw),
    .hitMon  (hitMon)
  );

  // Per-instance capability lookup, latched at the request
  pmid_inst_table uTab (
    .clk       (clk),
    .nrst      (nrst),
    .tableBits (CSU_TABLE),
    .rdInst    (RIS_ON ? partSelInst : 4'h0),
    .rdData    (csuBits)
  );

  // Pick one field of a per-instance table
  function automatic logic [31:0] priWord(input logic [pmid_pkg::INST_W-1:0] i);
    priWord = PRI_TABLE[i*32 +: 32];
  endfunction : priWord

  // Request capture; writes are accepted and dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_r <= 2'h0;
      hit_r  <= 3'h0;
      rd_r   <= 1'b0;
      inst_r <= 4'h0;
    end else if (state_r == pmid_pkg::ST_IDLE && req) begin
      page_r <= page;
      hit_r  <= pageOk ? {hitPri, hitNrw, hitMon} : 3'h0;
      rd_r   <= !wr;
      inst_r <= RIS_ON ? partSelInst : 4'h0;
    end
  end

  // Bus sequence: idle, lookup, answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= pmid_pkg::ST_IDLE;
    end else begin
      case (state_r)
        pmid_pkg::ST_IDLE: state_r <= req ? pmid_pkg::ST_LOOK : pmid_pkg::ST_IDLE;
        pmid_pkg::ST_LOOK: state_r <= pmid_pkg::ST_DONE;
        pmid_pkg::ST_DONE: state_r <= pmid_pkg::ST_IDLE;
        default:           state_r <= pmid_pkg::ST_IDLE;
      endcase
    end
  end

  // Form the answer from the captured hit and page
  always_comb begin
    rdata_nxt = 32'h0;
    if (rd_r) begin
      if (hit_r[0] && MON_ON) begin
        // Separate bit per page, per instance
        rdata_nxt[pmid_pkg::CSU_BIT] = csuBits[page_r];
      end else if (hit_r[1] && NRW_ON) begin
        // Per-page value, upper bits zero
        rdata_nxt[pmid_pkg::NRW_MAX_LSB +: pmid_pkg::NRW_MAX_W] =
          NRW_MAX[page_r*16 +: 16];
      end else if (hit_r[2] && PRI_ON) begin
        rdata_nxt = priWord(inst_r);
      end
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack   <= 1'b0;
      rdata <= pmid_pkg::RDATA_RESET;
      busy  <= 1'b0;
    end else begin
      ack  <= (state_r == pmid_pkg::ST_LOOK);
      busy <= (state_r == pmid_pkg::ST_IDLE) ? req : (state_r == pmid_pkg::ST_LOOK);
      if (state_r == pmid_pkg::ST_LOOK) begin
        rdata <= rdata_nxt;
      end
    end
  end

  // Answer follows a request by exactly two cycles
  sequence sReq;
    (state_r == pmid_pkg::ST_IDLE) && req;
  endsequence
  a_ack_timing: assert property (@(posedge clk) disable iff (!nrst)
    sReq |-> ##2 ack) else $error("answer not two cycles after request");

  // Upper narrowing bits read zero
  a_nrw_upper: assert property (@(posedge clk) disable iff (!nrst)
    ack && hit_r[1] |-> rdata[31:16] == 16'h0) else $error("narrowing upper bits set");

  // Write answers read zero
  a_write_zero: assert property (@(posedge clk) disable iff (!nrst)
    ack && !rd_r |-> rdata == 32'h0) else $error("write returned data");

  // Monitoring read carries only the presence bit
  a_mon_only: assert property (@(posedge clk) disable iff (!nrst)
    ack && hit_r[0] |-> (rdata & ~(32'h1 << pmid_pkg::CSU_BIT)) == 32'h0)
    else $error("monitoring register reserved bits set");

  // Absent monitoring reads zero
  a_mon_absent: assert property (@(posedge clk) disable iff (!nrst)
    ack && hit_r[0] && !MON_ON |-> rdata == 32'h0) else $error("absent monitor read nonzero");

  // Absent priority register reads zero
  a_pri_absent: assert property (@(posedge clk) disable iff (!nrst)
    ack && hit_r[2] && !PRI_ON |-> rdata == 32'h0) else $error("absent priority read nonzero");

  // Root and realm without the feature hit nothing
  a_page_gate: assert property (@(posedge clk) disable iff (!nrst)
    (sReq and (!REALM_ON && page[1])) |=> hit_r == 3'h0) else $error("root page decoded");

  // Narrowing value matches its page
  a_nrw_page: assert property (@(posedge clk) disable iff (!nrst)
    ack && rd_r && hit_r[1] && NRW_ON |-> rdata[15:0] == NRW_MAX[page_r*16 +: 16])
    else $error("narrowing value wrong for page");

  // Busy covers the request until the answer
  a_busy_span: assert property (@(posedge clk) disable iff (!nrst)
    sReq |=> busy ##1 (busy && ack) ##1 !busy) else $error("busy span wrong");

  // Length of the present busy run, for the span bound
  logic [2:0] busyRun_r;                               // Saturating run counter

  // Count consecutive busy cycles, cleared when busy drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busyRun_r <= 3'h0;
    end else if (!busy) begin
      busyRun_r <= 3'h0;                               // Run over
    end else if (busyRun_r != 3'h7) begin
      busyRun_r <= busyRun_r + 3'h1;                   // Still busy
    end
  end

  // Steps of one transfer after the taking edge
  sequence sLook;
    state_r == pmid_pkg::ST_LOOK;
  endsequence
  sequence sAnswer;
    ack && busy;
  endsequence
  sequence sRelease;
    !ack && !busy && (state_r == pmid_pkg::ST_IDLE);
  endsequence

  // Whole walk of one transfer
  a_state_walk: assert property (@(posedge clk) disable iff (!nrst)
    sReq |=> sLook ##1 sAnswer ##1 sRelease)
    else $error("transfer walk broken");

  // Ack is a single-cycle pulse
  a_ack_pulse: assert property (@(posedge clk) disable iff (!nrst)
    ack |=> !ack)
    else $error("ack longer than one cycle");

  // Ack only in the answer state
  a_ack_state: assert property (@(posedge clk) disable iff (!nrst)
    ack |-> state_r == pmid_pkg::ST_DONE)
    else $error("ack outside answer state");

  // State register stays one-hot
  a_state_onehot: assert property (@(posedge clk) disable iff (!nrst)
    $onehot(state_r))
    else $error("state not one-hot");

  // Answer state always returns to idle
  a_done_return: assert property (@(posedge clk) disable iff (!nrst)
    state_r == pmid_pkg::ST_DONE |=> state_r == pmid_pkg::ST_IDLE)
    else $error("answer state not left");

  // At most one register hit per request
  a_hit_onehot: assert property (@(posedge clk) disable iff (!nrst)
    $onehot0(hit_r))
    else $error("several registers hit");

  // Busy never outlasts two cycles
  a_busy_bound: assert property (@(posedge clk) disable iff (!nrst)
    busyRun_r <= 3'h2)
    else $error("busy run too long");

  // No request in idle leaves busy low
  a_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == pmid_pkg::ST_IDLE) && !req |=> !busy)
    else $error("busy without request");

  // Requests while busy are dropped
  a_req_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (state_r != pmid_pkg::ST_IDLE) && req |=>
      $stable(page_r) && $stable(hit_r) && $stable(inst_r))
    else $error("request taken while busy");

  // Read data holds between answers
  a_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
    !ack |-> $stable(rdata))
    else $error("read data changed without ack");

  // Monitoring bit follows the captured instance row
  a_csu_inst: assert property (@(posedge clk) disable iff (!nrst)
    ack && rd_r && hit_r[0] && MON_ON |->
      rdata[pmid_pkg::CSU_BIT] == CSU_TABLE[inst_r*4 + page_r])
    else $error("monitor bit not from selected instance");

  // Priority word follows the captured instance
  a_pri_inst: assert property (@(posedge clk) disable iff (!nrst)
    ack && rd_r && hit_r[2] && PRI_ON |-> rdata == PRI_TABLE[inst_r*32 +: 32])
    else $error("priority word not from selected instance");

  // Absent narrowing register reads zero
  a_nrw_absent: assert property (@(posedge clk) disable iff (!nrst)
    ack && hit_r[1] && !NRW_ON |-> rdata == 32'h0)
    else $error("absent narrowing read nonzero");

  // Root and realm read zero without the realm feature
  a_root_zero: assert property (@(posedge clk) disable iff (!nrst)
    ack && !REALM_ON && page_r[1] |-> rdata == 32'h0)
    else $error("root or realm page answered");

  // Unmapped offsets read zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    ack && (hit_r == 3'h0) |-> rdata == 32'h0)
    else $error("unmapped offset read nonzero");

  // Page is captured at the taking edge
  a_page_capture: assert property (@(posedge clk) disable iff (!nrst)
    sReq |=> page_r == $past(page))
    else $error("page not captured");

  // Instance comes from the partition select field only
  a_inst_capture: assert property (@(posedge clk) disable iff (!nrst)
    sReq |=> inst_r == (RIS_ON ? $past(partSelInst) : 4'h0))
    else $error("instance not from partition select");

  // Read flag is captured with the request
  a_rd_capture: assert property (@(posedge clk) disable iff (!nrst)
    sReq |=> rd_r == !$past(wr))
    else $error("read flag not captured");

  // A write is answered with zero data
  a_write_answer: assert property (@(posedge clk) disable iff (!nrst)
    (sReq and wr) |-> ##2 (ack && rdata == 32'h0))
    else $error("write not answered with zero");

endmodule : pmid_id_regs

// ===== verif/test_pmid_id_regs.sv
// Self-checking testbench of the identification register bank
`timescale 1ns/1ps
module test_pmid_id_regs;
  localparam logic [63:0]  CSU_T = 64'h0000_f0f0_ffff_00ff;        // Per instance and page
  localparam logic [63:0]  NRW_T = 64'h003f_001f_00ff_007f;        // Per page maximum
  localparam logic [511:0] PRI_T = {8{64'h0003_0011_0002_0010}};   // Alternating per instance
  logic        clk;                                               // System clock
  logic        nrst;                                              // Reset, active low
  logic        req;                                               // Request strobe
  logic        wr;                                                // Write flag
  logic [13:0] addr;                                              // Byte address
  logic [31:0] wdata;                                             // Write data
  logic [3:0]  partSelInst;                                       // Selected instance
  logic [3:0]  monSelInst;                                        // Monitor select, ignored
  logic        ackA, ackB, busyA, busyB;                          // Handshake outputs
  logic [31:0] rdA, rdB;                                          // Read data outputs
  int          nErrors = 0;                                       // Mismatch count
  int          checked = 0;                                       // Comparison count
  int          cyc = 0;                                           // Cycle counter for timeout
  logic [31:0] expQ [$];                                          // Model answers in flight
  logic [11:0] offs [4] = '{12'h048, 12'h050, 12'h080, 12'h044};  // Offsets in play
  // Full build, every feature on
  pmid_id_regs #(.CSU_TABLE(CSU_T), .NRW_MAX(NRW_T), .PRI_TABLE(PRI_T)) u_pmid_id_regs (
    .clk(clk), .nrst(nrst), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
    .partSelInst(partSelInst), .monSelInst(monSelInst), .ack(ackA), .rdata(rdA), .busy(busyA));
  // Reduced build: no realm, monitoring, narrowing, priority or instance select
  pmid_id_regs #(.REALM_ON(1'b0), .MON_ON(1'b0), .NRW_ON(1'b0), .PRI_ON(1'b0), .RIS_ON(1'b0),
    .CSU_TABLE(CSU_T), .NRW_MAX(NRW_T), .PRI_TABLE(PRI_T)) u_pmid_id_regs_off (
    .clk(clk), .nrst(nrst), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
    .partSelInst(partSelInst), .monSelInst(monSelInst), .ack(ackB), .rdata(rdB), .busy(busyB));
  // Free-running clock
  always #5 clk = ~clk;
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nErrors = nErrors + 1;
      tally_and_finish();
    end
  end
  // Reference model of the read data
  function automatic logic [31:0] expv(bit full, logic w, logic [13:0] a, logic [3:0] i);
    logic [1:0]  p;
    logic [11:0] o;
    p = a[13:12];
    o = a[11:0];
    if (w || (!full && p[1])) return 32'h0;  // Writes and absent pages read zero
    if (o == pmid_pkg::NRW_IDR_OFFSET && full) return {16'h0, NRW_T[p*16 +: 16]};
    if (o == pmid_pkg::MSMON_IDR_OFFSET && full) return {15'h0, CSU_T[i*4 + p], 16'h0};
    if (o == pmid_pkg::PRI_IDR_OFFSET && full) return PRI_T[i*32 +: 32];
    return 32'h0;
  endfunction : expv
  // One comparison with report
  task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
    checked = checked + 1;
    if (got !== exp) begin
      nErrors = nErrors + 1;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  // One register access; dbl keeps req up while busy, which must be ignored
  task automatic access(logic w, logic [13:0] a, logic [3:0] i, bit dbl);
    logic [31:0] ea, eb;
    ea = expv(1'b1, w, a, i);
    eb = expv(1'b0, w, a, i);
    expQ.push_back(ea);
    req = 1'b1;
    wr = w;
    addr = a;
    partSelInst = i;
    monSelInst = 4'($urandom);
    wdata = $urandom;
    @(negedge clk);
    if (!dbl) req = 1'b0;
    addr = ~a;                                   // Address no longer qualified
    partSelInst = ~i;                            // Selection moves after the take
    cmp({30'h0, busyA, busyB}, 32'h3, "busy");
    @(negedge clk);
    req = 1'b0;
    cmp({31'h0, ackA}, 32'h1, "ack full");
    cmp({31'h0, ackB}, 32'h1, "ack reduced");
    cmp(rdA, expQ.pop_front(), "read full");
    cmp(rdB, eb, "read reduced");
    @(negedge clk);
    cmp({28'h0, ackA, ackB, busyA, busyB}, 32'h0, "idle");
  endtask : access
  // Outputs while reset is held
  task automatic chk_reset();
    cmp(rdA | rdB, 32'h0, "reset rdata");
    cmp({28'h0, ackA, ackB, busyA, busyB}, 32'h0, "reset flags");
  endtask : chk_reset
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", nErrors, checked);
    if (nErrors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    addr = 14'h0;
    wdata = 32'h0;
    partSelInst = 4'h0;
    monSelInst = 4'h0;
    void'($urandom(32'h0f20));
    repeat (10) @(negedge clk);
    chk_reset();
    nrst = 1'b1;
    @(negedge clk);
    // Monitoring bit for every page and instance
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 16; i++) begin
        access(1'b0, {p[1:0], pmid_pkg::MSMON_IDR_OFFSET}, i[3:0], 1'b0);
      end
    end
    // Narrowing and priority across pages with instance changes
    for (int p = 0; p < 4; p++) begin
      access(1'b0, {p[1:0], pmid_pkg::NRW_IDR_OFFSET}, 4'(p * 5), 1'b0);
      access(1'b0, {p[1:0], pmid_pkg::PRI_IDR_OFFSET}, 4'(p + 1), 1'b1);
    end
    // Reset in mid-run with a nonzero answer on the bus
    nrst = 1'b0;
    @(negedge clk);
    chk_reset();
    nrst = 1'b1;
    @(negedge clk);
    // Random mix of reads, writes and unmapped offsets
    for (int n = 0; n < 300; n++) begin
      access(($urandom % 6) == 0, {2'($urandom), offs[$urandom % 4]}, 4'($urandom),
             ($urandom % 4) == 0);
    end
    tally_and_finish();
  end
endmodule : test_pmid_id_regs
